// [verilog/pct_timer.sv]
/*
  Periodic compare timer channel: APB register slave, prescaler, counter,
  compare-match flag and interrupt.
  Assumes an APB master on pclk and a single 200 MHz clock domain.
*/
// Local design decision: the APB slave port.
`timescale 1ns/100ps
module pct_timer import pct_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic start_reg, start_next;
  logic [6:0] ctrl_reg, ctrl_next;
  logic [1:0] mode_reg, mode_next;
  logic ien_reg, ien_next;
  logic flag_reg, flag_next;
  logic armed_reg, armed_next;
  logic [CNT_W-1:0] cmp_reg, cmp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;

  logic setup, access, wr, rd;
  logic hit_start, hit_ctrl, hit_mode, hit_ien, hit_stat, hit_cnt, hit_cmp, hit_any;
  logic [CNT_W-1:0] count;
  logic match, run;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  always_comb begin
    hit_start = (paddr == byte_addr(IDX_START));
    hit_ctrl = (paddr == byte_addr(IDX_CTRL));
    hit_mode = (paddr == byte_addr(IDX_MODE));
    hit_ien = (paddr == byte_addr(IDX_IEN));
    hit_stat = (paddr == byte_addr(IDX_STAT));
    hit_cnt = (paddr == byte_addr(IDX_CNT));
    hit_cmp = (paddr == byte_addr(IDX_CMP));
    hit_any = hit_start | hit_ctrl | hit_mode | hit_ien | hit_stat | hit_cnt | hit_cmp;
    setup = psel & ~penable;
    access = psel & penable;
    wr = access & pwrite & hit_any;
    rd = access & ~pwrite & hit_any;
  end

  // ----------------------------------------
  // Counting engine
  // ----------------------------------------
  pct_tick_if tk ();

  assign tk.prescale_sel = ctrl_reg[PSC_LSB +: 3];
  assign tk.clock_edge = ctrl_reg[EDGE_LSB +: 2];
  // Other modes are not built here, so they leave the counter parked
  assign run = start_reg & (mode_reg == MODE_NORMAL);

  pct_prescaler u_psc (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk)
  );

  pct_counter u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .tk(tk),
    .run(run),
    .clear_on_match(ctrl_reg[CLR_LSB +: 2] == CLR_ON_CMP_A),
    .cnt_we(wr & hit_cnt),
    .cnt_wdata(pwdata[CNT_W-1:0]),
    .cmp(cmp_reg),
    .count(count),
    .match(match)
  );

  // ----------------------------------------
  // Register writes, flag and read data
  // ----------------------------------------
  always_comb begin
    start_next = start_reg;
    ctrl_next = ctrl_reg;
    mode_next = mode_reg;
    ien_next = ien_reg;
    cmp_next = cmp_reg;
    flag_next = flag_reg;
    armed_next = armed_reg;
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (wr) begin
      if (hit_start) start_next = pwdata[START_BIT];
      if (hit_ctrl) ctrl_next = pwdata[6:0];
      if (hit_mode) mode_next = pwdata[MODE_LSB +: 2];
      if (hit_ien) ien_next = pwdata[IEN_BIT];
      if (hit_cmp) cmp_next = pwdata[CNT_W-1:0];
    end
    // A read that sees the flag set arms the clear; a one written leaves the flag set but disarms the clear
    if (rd && hit_stat && flag_reg) begin
      armed_next = 1'b1;
    end
    if (wr && hit_stat) begin
      if (armed_reg && !pwdata[FLAG_BIT]) flag_next = 1'b0;
      armed_next = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (match) begin
      flag_next = 1'b1;
    end
    if (setup) begin
      rdata_next = '0;
      err_next = ~hit_any;
      unique case (1'b1)
        hit_start: rdata_next[START_BIT] = start_reg;
        hit_ctrl: rdata_next[6:0] = ctrl_reg;
        hit_mode: rdata_next[MODE_LSB +: 2] = mode_reg;
        hit_ien: rdata_next[IEN_BIT] = ien_reg;
        hit_stat: rdata_next[FLAG_BIT] = flag_reg;
        hit_cnt: rdata_next[CNT_W-1:0] = count;
        hit_cmp: rdata_next[CNT_W-1:0] = cmp_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 1'b0;
      ctrl_reg <= CTRL8_RST[6:0];
      mode_reg <= CTRL8_RST[1:0];
      ien_reg <= 1'b0;
      cmp_reg <= CMP_RST;
      flag_reg <= 1'b0;
      armed_reg <= 1'b0;
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end else begin
      start_reg <= start_next;
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
      ien_reg <= ien_next;
      cmp_reg <= cmp_next;
      flag_reg <= flag_next;
      armed_reg <= armed_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  // ----------------------------------------
  // Bus answers and interrupt
  // ----------------------------------------
  // Zero wait states: read data is captured during the setup cycle
  assign pready = 1'b1;
  assign pslverr = access & err_reg;
  assign prdata = rdata_reg;
  assign irq = flag_reg & ien_reg;
endmodule // pct_timer

// [verilog/pct_pkg.sv]
/*
  Constants, register map and field layout of the periodic compare timer channel.
  Assumes nothing of its surroundings; imported whole by every module of the block.
*/
package pct_pkg;
  localparam int ADDR_W = 20;
  localparam int CNT_W = 16;
  localparam int PSC_W = 10;
  // ----------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------
  localparam logic [15:0] IDX_START = 16'hf030;
  localparam logic [15:0] IDX_CTRL = 16'hf040;
  localparam logic [15:0] IDX_MODE = 16'hf041;
  localparam logic [15:0] IDX_IEN = 16'hf044;
  localparam logic [15:0] IDX_STAT = 16'hf045;
  localparam logic [15:0] IDX_CNT = 16'hf046;
  localparam logic [15:0] IDX_CMP = 16'hf048;
  // ----------------------------------------
  // Field positions and codes
  // ----------------------------------------
  localparam int START_BIT = 1;
  localparam int CLR_LSB = 5;
  localparam int EDGE_LSB = 3;
  localparam int PSC_LSB = 0;
  localparam int MODE_LSB = 0;
  localparam int FLAG_BIT = 0;
  localparam int IEN_BIT = 0;
  localparam logic [1:0] CLR_ON_CMP_A = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [2:0] PSC_DIV256 = 3'h6;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'hffff;
  localparam logic [7:0] CTRL8_RST = 8'h00;

  typedef enum logic [1:0] {
    PCT_EDGE_RISE = 2'b00,
    PCT_EDGE_FALL = 2'b01,
    PCT_EDGE_BOTH = 2'b10
  } pct_edge_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    return {2'h0, idx, 2'b00};
  endfunction

  // Divide ratio is two to the returned power
  function automatic logic [3:0] div_pow(input logic [2:0] sel);
    unique case (sel)
      3'h0: return 4'h0;
      3'h1: return 4'h2;
      3'h2: return 4'h4;
      3'h3: return 4'h6;
      3'h4: return 4'h1;
      3'h5: return 4'h3;
      PSC_DIV256: return 4'h8;
      3'h7: return 4'ha;
    endcase
  endfunction
endpackage

// [verilog/pct_tick_if.sv]
/*
  Carries the clock selection to the prescaler and its count tick to the counter.
  Assumes one clock, pclk, for both ends.
*/
`timescale 1ns/100ps
interface pct_tick_if;
  logic [2:0] prescale_sel;
  logic [1:0] clock_edge;
  logic tick;
  modport src (input prescale_sel, input clock_edge, output tick);
  modport cnt (input tick);
endinterface

// [verilog/pct_prescaler.sv]
/*
  Prescaler: divides pclk by a power of two and emits one-cycle count ticks
  on the selected edge of the divided clock, or on every cycle when undivided.
  Assumes selection fields driven from registers in the pclk domain.
*/
`timescale 1ns/100ps
module pct_prescaler import pct_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  pct_tick_if.src tk
);
  logic [PSC_W-1:0] div_reg, div_next;
  logic tap_reg, tap_next;
  logic [3:0] pw;
  logic tap, rise, fall;

  always_comb begin
    pw = div_pow(tk.prescale_sel);
    div_next = div_reg + 1'b1;
    tap = (pw == 4'h0) ? 1'b0 : div_reg[pw - 4'h1];
    tap_next = tap;
    rise = tap & ~tap_reg;
    fall = ~tap & tap_reg;
    // Undivided clock counts every cycle whatever the edge field says
    if (pw == 4'h0) begin
      tk.tick = 1'b1;
    end else begin
      unique case (tk.clock_edge)
        PCT_EDGE_RISE: tk.tick = rise;
        PCT_EDGE_FALL: tk.tick = fall;
        default: tk.tick = rise | fall;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
      tap_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tap_reg <= tap_next;
    end
  end
endmodule // pct_prescaler

// [verilog/pct_counter.sv]
/*
  Channel counter with compare match and optional clear on match.
  Assumes compare value and controls are registers in the pclk domain.
*/
`timescale 1ns/100ps
module pct_counter import pct_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  pct_tick_if.cnt tk,
  input wire logic run,
  input wire logic clear_on_match,
  input wire logic cnt_we,
  input wire logic [CNT_W-1:0] cnt_wdata,
  input wire logic [CNT_W-1:0] cmp,
  output logic [CNT_W-1:0] count,
  output logic match
);
  logic [CNT_W-1:0] count_reg, count_next;

  always_comb begin
    // Match only when a tick is taken, so a stopped counter raises none
    match = run & tk.tick & (count_reg == cmp);
    count_next = count_reg;
    if (cnt_we) begin
      count_next = cnt_wdata;
    end else if (run && tk.tick) begin
      if (match && clear_on_match) begin
        count_next = '0;
      end else begin
        count_next = count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= CNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
endmodule // pct_counter

// [dv/pct_timer_props.sv]
/*
  Port checker of the periodic compare timer channel.
  Assumes binding into pct_timer; one pclk domain.
*/
`timescale 1ns/100ps
module pct_timer_props import pct_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  // ----------------------------------------
  // Shadow of software state
  // ----------------------------------------
  logic acc, wr, rd, cfg, mapped;
  logic ien_reg, ien_next, run_reg, run_next, known_reg, known_next;
  logic [15:0] cmp_reg, cmp_next, cnt_reg, cnt_next;
  function automatic logic at(input logic [15:0] i);
    return paddr == {2'h0, i, 2'b00};
  endfunction
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign cfg = wr && (at(IDX_STAT) || at(IDX_IEN));
  assign mapped = at(IDX_START) || at(IDX_CTRL) || at(IDX_MODE) || at(IDX_IEN) || at(IDX_STAT) || at(IDX_CNT)
    || at(IDX_CMP);
  // Counter value is only predictable while stopped since its last write
  always_comb begin
    ien_next = ien_reg;
    cmp_next = cmp_reg;
    cnt_next = cnt_reg;
    run_next = run_reg;
    known_next = known_reg;
    if (wr && at(IDX_IEN)) ien_next = pwdata[IEN_BIT];
    if (wr && at(IDX_CMP)) cmp_next = pwdata[15:0];
    if (wr && at(IDX_START)) begin
      run_next = pwdata[START_BIT];
      known_next = known_reg && !pwdata[START_BIT];
    end
    if (wr && at(IDX_CNT)) begin
      cnt_next = pwdata[15:0];
      known_next = !run_reg;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_reg <= 1'b0;
      cmp_reg <= 16'hffff;
      cnt_reg <= 16'h0000;
      run_reg <= 1'b0;
      known_reg <= 1'b1;
    end else begin
      ien_reg <= ien_next;
      cmp_reg <= cmp_next;
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      known_reg <= known_next;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  err_decode_a: assert property (acc |-> pslverr == !mapped) else $error("slave error does not match decode");
  err_phase_a: assert property (pslverr |-> acc) else $error("slave error outside access phase");
  rd_unmapped_a: assert property (rd && !mapped |-> prdata == 32'h0) else $error("unmapped read not zero");
  cmp_read_a: assert property (rd && at(IDX_CMP) |-> prdata == {16'h0, cmp_reg})
    else $error("compare readback wrong");
  cnt_hold_a: assert property (rd && at(IDX_CNT) && known_reg |-> prdata == {16'h0, cnt_reg})
    else $error("stopped counter moved");
  irq_mask_a: assert property (irq |-> ien_reg || $past(ien_reg)) else $error("irq while disabled");
  irq_sticky_a: assert property (irq && !cfg && !$past(cfg) |=> irq) else $error("irq dropped");
  write_one_a: assert property (irq && wr && at(IDX_STAT) && pwdata[FLAG_BIT] && ien_reg |=> irq)
    else $error("write of one cleared flag");
endmodule // pct_timer_props
bind pct_timer pct_timer_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// [dv/pct_timer_tb.sv]
/*
  Self-checking bench of the timer channel over APB.
  Assumes pct_timer alone, byte address four times the register index.
*/
`timescale 1ns/100ps
module pct_timer_tb import pct_pkg::*;;
  // ----------------------------------------
  // Stimulus, tasks and scenarios
  // ----------------------------------------
  localparam logic [31:0] CTRL_PER = {25'h0, CLR_ON_CMP_A, 2'h0, PSC_DIV256};
  localparam logic [31:0] CTRL_FREE = {29'h0, PSC_DIV256};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat, v;
  logic pready, pslverr, irq, rerr;
  int n_errors = 0, tests_run = 0, cyc = 0, c1;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  pct_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle cycle after each transfer keeps one assignment per signal per step
  task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    // A slave that never answers counts against the run instead of passing silently
    if (n >= 50) n_errors++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [15:0] i, input logic [31:0] exp);
    apb(1'b0, i, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic wirq(input logic lv);
    int n;
    n = 0;
    while (irq !== lv && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, irq}, {31'h0, lv});
  endtask
  task automatic t_reset();
    logic [15:0] idx [7] = '{IDX_START, IDX_CTRL, IDX_MODE, IDX_IEN, IDX_STAT, IDX_CNT, IDX_CMP};
    for (int k = 0; k < 7; k++) rdc(idx[k], k == 6 ? 32'hffff : 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_map();
    apb(1'b1, IDX_CTRL, CTRL_PER);
    rdc(IDX_CTRL, CTRL_PER);
    apb(1'b1, IDX_MODE, {30'h0, MODE_NORMAL});
    rdc(IDX_MODE, 32'h0);
    apb(1'b1, IDX_CMP, 32'h3);
    rdc(IDX_CMP, 32'h3);
    apb(1'b1, 16'hf031, 32'hff);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, 16'hf031, 32'h0);
    chk({rdat[31:1], rerr}, 32'h1);
  endtask
  task automatic t_stopped();
    apb(1'b1, IDX_IEN, 32'h1);
    apb(1'b1, IDX_CNT, 32'h3);
    repeat (600) @(posedge pclk);
    rdc(IDX_CNT, 32'h3);
    rdc(IDX_STAT, 32'h0);
  endtask
  task automatic t_period();
    apb(1'b1, IDX_CNT, 32'h0);
    apb(1'b1, IDX_START, 32'h2);
    wirq(1'b1);
    c1 = cyc;
    rdc(IDX_STAT, 32'h1);
    apb(1'b1, IDX_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, IDX_STAT, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rdc(IDX_STAT, 32'h1);
    apb(1'b1, IDX_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wirq(1'b1);
    chk(cyc - c1, (32'h3 + 32'h1) * 32'd256);
    apb(1'b0, IDX_CNT, 32'h0);
    chk({31'h0, rdat[15:0] <= 16'h3}, 32'h1);
    apb(1'b1, IDX_IEN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rdc(IDX_STAT, 32'h1);
    apb(1'b1, IDX_IEN, 32'h1);
    chk({31'h0, irq}, 32'h1);
  endtask
  task automatic t_free();
    apb(1'b1, IDX_CTRL, CTRL_FREE);
    repeat (2048) @(posedge pclk);
    apb(1'b0, IDX_CNT, 32'h0);
    chk({31'h0, rdat[15:0] > 16'h3}, 32'h1);
    apb(1'b1, IDX_MODE, 32'h1);
    apb(1'b0, IDX_CNT, 32'h0);
    v = rdat;
    repeat (600) @(posedge pclk);
    rdc(IDX_CNT, v);
    apb(1'b1, IDX_MODE, {30'h0, MODE_NORMAL});
    apb(1'b1, IDX_START, 32'h0);
    apb(1'b0, IDX_CNT, 32'h0);
    v = rdat;
    repeat (600) @(posedge pclk);
    rdc(IDX_CNT, v);
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_map();
    t_stopped();
    t_period();
    t_free();
    stop_test();
  end
  // Whole run needs about 6000 cycles
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
endmodule // pct_timer_tb
